// [design/peripheral_trigger_interconnect.v]
// Function
// (R1) timer sync/chaining only in run/sleep family
// (R2) timer DMA trigger only in run/sleep family
// (R3) converter watchdog triggers advanced timer, not stop
// (R4) clock events to single timer a, not stop
// (R5) clock alarm to low-power timers; stop2 first only
// (R6) selected clock source to capture inputs, not stop
// (R7) fault events drive timer breaks, not stop
// (R8) gpio triggers per mode, stop2 first lp timer
// (R9) io analog, schmitt off during/after reset
// (R10) reset pull-up off on internal reset
// (R11) battery-only: ignore interrupts and clock alarms; code gates only the exit, STOP_WAKE_IRQ_OUT still fires
// (R12) standby/shutdown exit via two pins, clock
// (R13) shutdown pull settings dropped on exit
// (R14) serial receiver wakes on start/address/frame in stop; code wakes in stop 0/1 only
// (R15) two-wire address match wakes in stop; code wakes in stop 0/1 only
// (R16) fast oscillator on when radio needs it
// (R17) two sram clocks gated independently while sleeping
// (R18) per-mode registered gate, no spurious edges
`timescale 1ns/1ps
`include "trig_route_defs.vh"
module peripheral_trigger_interconnect #(
  parameter TRG_W = 4,
  parameter CLK_SRC_N = 8,
  parameter SEL_W = 3
) (
  input wire CLK_IN,
  input wire RST_B_IN,
  input wire [`MODE_W-1:0] POWER_MODE_IN,
  input wire [TRG_W-1:0] GENERAL_TIMERS_TRG_IN,
  input wire [TRG_W-1:0] GENERAL_TIMERS_DMA_TRG_IN,
  input wire CONVERTER_UNIT_WATCHDOG_IN,
  input wire RTC_EVENT_IN,
  input wire RTC_ALARM_TAMPER_IN,
  input wire [CLK_SRC_N-1:0] CLK_SOURCES_IN,
  input wire [SEL_W-1:0] WIDE_TIMER_CLK_SEL_IN,
  input wire [SEL_W-1:0] TIMER_A_CLK_SEL_IN,
  input wire [SEL_W-1:0] TIMER_B_CLK_SEL_IN,
  input wire CLOCK_FAILURE_DETECTOR_IN,
  input wire HARD_FAULT_IN,
  input wire SRAM_PARITY_ERR_IN,
  input wire FLASH_ECC_ERR_IN,
  input wire VOLTAGE_LEVEL_DETECTOR_IN,
  input wire GPIO_TRG_IN,
  input wire RESET_SRC_INTERNAL_IN,
  input wire IO_CONFIGURED_IN,
  input wire VBAT_ONLY_IN,
  input wire EXTI_IRQ_IN,
  input wire RTC_WAKE_IN,
  input wire [`WAKE_PIN_COUNT-1:0] WAKEUP_INPUTS_IN,
  input wire [1:0] SHUTDOWN_PULL_IN,
  input wire UART_START_IN,
  input wire UART_ADDR_MATCH_IN,
  input wire UART_FRAME_IN,
  input wire I2C_ADDR_MATCH_IN,
  input wire RF_ACTIVITY_REQ_IN,
  input wire [1:0] SRAM_CLK_GATE_REQ_IN,
  output wire [TRG_W-1:0] GENERAL_TIMERS_TRG_OUT,
  output wire [TRG_W-1:0] DMA_MEM2MEM_TRG_OUT,
  output wire ADVANCED_TIMER_TRG_OUT,
  output wire TIMER_A_RTC_CH_OUT,
  output wire FIRST_LOW_POWER_TIMER_TRG_OUT,
  output wire SECOND_LOW_POWER_TIMER_TRG_OUT,
  output wire WIDE_TIMER_CAPTURE_OUT,
  output wire TIMER_A_CAPTURE_OUT,
  output wire TIMER_B_CAPTURE_OUT,
  output wire ADVANCED_TIMER_BREAK_OUT,
  output wire TIMER_A_BREAK_OUT,
  output wire TIMER_B_BREAK_OUT,
  output wire GENERAL_TIMERS_EXT_TRG_OUT,
  output wire CONVERTER_UNIT_EXT_TRG_OUT,
  output wire FIRST_LP_TIMER_EXT_TRG_OUT,
  output wire SECOND_LP_TIMER_EXT_TRG_OUT,
  output reg IO_ANALOG_OUT,
  output reg IO_SCHMITT_EN_OUT,
  output reg RESET_PULLUP_EN_OUT,
  output reg LOW_POWER_EXIT_OUT,
  output reg [1:0] IO_PULL_OUT,
  output reg STOP_WAKE_IRQ_OUT,
  output reg FAST_EXTERNAL_OSCILLATOR_EN_OUT,
  output reg [1:0] SRAM_CLK_EN_OUT
);
  // mode decode, registered so gates switch on a clean edge
  reg [`MODE_W-1:0] mode_reg;
  wire run_family;
  wire stop01;
  wire stop2;
  wire stop_any;
  wire low_standby;
  wire asleep;

  function run_fam;
    input [`MODE_W-1:0] m;
    begin
      run_fam = (m == `MODE_RUN) || (m == `MODE_SLEEP) ||
        (m == `MODE_LP_RUN) || (m == `MODE_LP_SLEEP);
    end
  endfunction

  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mode_reg <= `MODE_RUN;
    end else begin
      mode_reg <= POWER_MODE_IN;
    end
  end

  assign run_family = run_fam(mode_reg);
  assign stop01 = (mode_reg == `MODE_STOP01);
  assign stop2 = (mode_reg == `MODE_STOP2);
  assign stop_any = stop01 | stop2;
  assign low_standby = (mode_reg == `MODE_STANDBY) || (mode_reg == `MODE_SHUTDOWN);
  assign asleep = (mode_reg == `MODE_SLEEP) || (mode_reg == `MODE_LP_SLEEP);

  // only pin-level and clock sources are synchronised; peripheral events share CLK_IN
  wire gpio_s;
  wire [`WAKE_PIN_COUNT-1:0] wake_s;
  wire [CLK_SRC_N-1:0] clk_src_s;
  sync2 #(.WIDTH(1 + `WAKE_PIN_COUNT + CLK_SRC_N)) u_pin_sync (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .d_in({GPIO_TRG_IN, WAKEUP_INPUTS_IN, CLK_SOURCES_IN}),
    .q_out({gpio_s, wake_s, clk_src_s})
  );

  // clock measurement: sampling limits this to sources below half of CLK_IN
  wire [2:0] cap_sel;
  assign cap_sel = {clk_src_s[WIDE_TIMER_CLK_SEL_IN], clk_src_s[TIMER_A_CLK_SEL_IN],
    clk_src_s[TIMER_B_CLK_SEL_IN]};

  wire any_break;
  assign any_break = CLOCK_FAILURE_DETECTOR_IN | HARD_FAULT_IN | SRAM_PARITY_ERR_IN |
    FLASH_ECC_ERR_IN | VOLTAGE_LEVEL_DETECTOR_IN;

  // run/sleep-family routes, one gate per route group so each group can be retimed alone
  mode_gate #(.WIDTH(TRG_W)) u_sync_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R1]
    .sig_in(GENERAL_TIMERS_TRG_IN),
    .sig_out(GENERAL_TIMERS_TRG_OUT)
  );

  mode_gate #(.WIDTH(TRG_W)) u_dma_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R2]
    .sig_in(GENERAL_TIMERS_DMA_TRG_IN),
    .sig_out(DMA_MEM2MEM_TRG_OUT)
  );

  mode_gate #(.WIDTH(1)) u_wdog_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R3]
    .sig_in(CONVERTER_UNIT_WATCHDOG_IN),
    .sig_out(ADVANCED_TIMER_TRG_OUT)
  );

  mode_gate #(.WIDTH(1)) u_rtc_ch_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R4]
    .sig_in(RTC_EVENT_IN),
    .sig_out(TIMER_A_RTC_CH_OUT)
  );

  mode_gate #(.WIDTH(3)) u_cap_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R6]
    .sig_in(cap_sel),
    .sig_out({WIDE_TIMER_CAPTURE_OUT, TIMER_A_CAPTURE_OUT, TIMER_B_CAPTURE_OUT})
  );

  mode_gate #(.WIDTH(3)) u_break_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R7]
    .sig_in({3{any_break}}),
    .sig_out({ADVANCED_TIMER_BREAK_OUT, TIMER_A_BREAK_OUT, TIMER_B_BREAK_OUT})
  );

  mode_gate #(.WIDTH(2)) u_ext_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family), // [R8]
    .sig_in({2{gpio_s}}),
    .sig_out({GENERAL_TIMERS_EXT_TRG_OUT, CONVERTER_UNIT_EXT_TRG_OUT})
  );

  // first low-power timer keeps its routes down to stop 2
  mode_gate #(.WIDTH(2)) u_lp1_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family | stop_any), // [R5] [R8]
    .sig_in({RTC_ALARM_TAMPER_IN, gpio_s}),
    .sig_out({FIRST_LOW_POWER_TIMER_TRG_OUT, FIRST_LP_TIMER_EXT_TRG_OUT})
  );

  // second one keeps them down to stop 0/1, blocked in stop 2
  mode_gate #(.WIDTH(2)) u_lp2_gate (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .allow_in(run_family | stop01), // [R5] [R8]
    .sig_in({RTC_ALARM_TAMPER_IN, gpio_s}),
    .sig_out({SECOND_LOW_POWER_TIMER_TRG_OUT, SECOND_LP_TIMER_EXT_TRG_OUT})
  );

  // io state: analog until software configures the pins
  reg shutdown_seen_reg;
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IO_ANALOG_OUT <= 1'b1;
      IO_SCHMITT_EN_OUT <= 1'b0;
      RESET_PULLUP_EN_OUT <= 1'b1;
    end else begin
      IO_ANALOG_OUT <= ~IO_CONFIGURED_IN; // [R9]
      IO_SCHMITT_EN_OUT <= IO_CONFIGURED_IN; // [R9]
      RESET_PULLUP_EN_OUT <= (RESET_SRC_INTERNAL_IN != `RST_SRC_INTERNAL); // [R10]
    end
  end

  // pull setting only lives while in shutdown
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IO_PULL_OUT <= 2'h0;
      shutdown_seen_reg <= 1'b0;
    end else begin
      shutdown_seen_reg <= (mode_reg == `MODE_SHUTDOWN);
      if (mode_reg == `MODE_SHUTDOWN) begin
        IO_PULL_OUT <= SHUTDOWN_PULL_IN;
      end else if (shutdown_seen_reg) begin
        IO_PULL_OUT <= 2'h0; // [R13]
      end
    end
  end

  // wake and exit logic
  reg exit_next;
  wire uart_wake;
  assign uart_wake = UART_START_IN | UART_ADDR_MATCH_IN | UART_FRAME_IN; // [R14]

  always @* begin
    exit_next = 1'b0;
    if (VBAT_ONLY_IN) begin
      exit_next = 1'b0; // [R11]
    end else if (low_standby) begin
      exit_next = (|wake_s) | RTC_WAKE_IN; // [R12]
    end else if (stop_any) begin
      exit_next = EXTI_IRQ_IN | RTC_WAKE_IN;
    end
  end

  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      LOW_POWER_EXIT_OUT <= 1'b0;
      STOP_WAKE_IRQ_OUT <= 1'b0;
      FAST_EXTERNAL_OSCILLATOR_EN_OUT <= 1'b0;
      SRAM_CLK_EN_OUT <= 2'h3;
    end else begin
      LOW_POWER_EXIT_OUT <= exit_next; // [R11] [R12]
      STOP_WAKE_IRQ_OUT <= stop01 & (uart_wake | I2C_ADDR_MATCH_IN); // [R14] [R15]
      FAST_EXTERNAL_OSCILLATOR_EN_OUT <= RF_ACTIVITY_REQ_IN; // [R16]
      SRAM_CLK_EN_OUT <= asleep ? ~SRAM_CLK_GATE_REQ_IN : 2'h3; // [R17]
    end
  end
endmodule // peripheral_trigger_interconnect

// [design/trig_route_defs.vh]
`ifndef TRIG_ROUTE_DEFS_VH
`define TRIG_ROUTE_DEFS_VH
// power mode encoding
`define MODE_W 3
`define MODE_RUN 3'h0
`define MODE_SLEEP 3'h1
`define MODE_LP_RUN 3'h2
`define MODE_LP_SLEEP 3'h3
`define MODE_STOP01 3'h4
`define MODE_STOP2 3'h5
`define MODE_STANDBY 3'h6
`define MODE_SHUTDOWN 3'h7
// reset source field
`define RST_SRC_PIN 1'h0
`define RST_SRC_INTERNAL 1'h1
// wake pin positions
`define WAKE_PIN_A_BIT 0
`define WAKE_PIN_B_BIT 1
`define WAKE_PIN_COUNT 2
// oscillator frequency in MHz
`define FAST_EXT_OSC_MHZ 32
`endif

// [design/mode_gate.v]
`timescale 1ns/1ps
// registered and-gate: a blocked route holds low, so a mode change gives no stray edge
module mode_gate #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire allow_in,
  input wire [WIDTH-1:0] sig_in,
  output reg [WIDTH-1:0] sig_out
);
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sig_out <= {WIDTH{1'b0}};
    end else begin
      sig_out <= allow_in ? sig_in : {WIDTH{1'b0}}; // [R18]
    end
  end
endmodule // mode_gate

// [design/sync2.v]
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire [WIDTH-1:0] d_in,
  output reg [WIDTH-1:0] q_out
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= {WIDTH{1'b0}};
      q_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // sync2

// [testbench/trig_far_end.sv]
`timescale 1ns/1ps
// sparse random pulses, as event sources fire now and then
module trig_far_end (
  input wire clk_in,
  output reg [15:0] trg_out = 16'h0000
);
  always @(posedge clk_in) begin
    trg_out <= $urandom & $urandom;
  end
endmodule // trig_far_end

// [testbench/peripheral_trigger_interconnect_properties.sv]
`timescale 1ns/1ps
module pti_properties #(
  parameter TRG_W = 4
) (
  input wire CLK_IN,
  input wire RST_B_IN,
  input wire [2:0] POWER_MODE_IN,
  input wire [TRG_W-1:0] GENERAL_TIMERS_TRG_IN,
  input wire CONVERTER_UNIT_WATCHDOG_IN,
  input wire RTC_ALARM_TAMPER_IN,
  input wire RESET_SRC_INTERNAL_IN,
  input wire [TRG_W-1:0] GENERAL_TIMERS_TRG_OUT,
  input wire [TRG_W-1:0] DMA_MEM2MEM_TRG_OUT,
  input wire ADVANCED_TIMER_TRG_OUT,
  input wire FIRST_LOW_POWER_TIMER_TRG_OUT,
  input wire SECOND_LOW_POWER_TIMER_TRG_OUT,
  input wire ADVANCED_TIMER_BREAK_OUT,
  input wire RESET_PULLUP_EN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  reg [1:0] up_reg;
  reg [2:0] m1_reg;
  reg [2:0] m2_reg;
  wire on = up_reg == 2'h3;
  // mode history means nothing until three edges after reset have passed
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) up_reg <= 2'h0;
    else if (!on) up_reg <= up_reg + 2'h1;
  end
  always @(posedge CLK_IN) begin
    m1_reg <= POWER_MODE_IN;
    m2_reg <= m1_reg;
  end
  property p_sync;
    on && m2_reg < 3'h4 |-> GENERAL_TIMERS_TRG_OUT == $past(GENERAL_TIMERS_TRG_IN);
  endproperty
  a_sync: assert property (p_sync) else $error("sync route lost");
  property p_noleak; on && m2_reg > 3'h3 |-> GENERAL_TIMERS_TRG_OUT == 0; endproperty
  a_noleak: assert property (p_noleak) else $error("sync leaks in stop");
  property p_dma; on && m2_reg > 3'h3 |-> DMA_MEM2MEM_TRG_OUT == 0; endproperty
  a_dma: assert property (p_dma) else $error("dma trigger in stop");
  property p_wdog; on |-> ADVANCED_TIMER_TRG_OUT ==
    ($past(CONVERTER_UNIT_WATCHDOG_IN) && m2_reg < 3'h4); endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog route wrong");
  property p_lp1;
    on |-> FIRST_LOW_POWER_TIMER_TRG_OUT == ($past(RTC_ALARM_TAMPER_IN) && m2_reg < 3'h6);
  endproperty
  a_lp1: assert property (p_lp1) else $error("first lp alarm wrong");
  property p_lp2;
    on |-> SECOND_LOW_POWER_TIMER_TRG_OUT == ($past(RTC_ALARM_TAMPER_IN) && m2_reg < 3'h5);
  endproperty
  a_lp2: assert property (p_lp2) else $error("second lp alarm wrong");
  property p_brk; on && m2_reg > 3'h3 |-> !ADVANCED_TIMER_BREAK_OUT; endproperty
  a_brk: assert property (p_brk) else $error("break in stop");
  property p_pull; up_reg != 2'h0 && RESET_SRC_INTERNAL_IN |=> !RESET_PULLUP_EN_OUT; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on");
endmodule // pti_properties
bind peripheral_trigger_interconnect pti_properties #(.TRG_W(TRG_W)) u_props (.*);

// [testbench/peripheral_trigger_interconnect_tb_top.sv]
`timescale 1ns/1ps
module peripheral_trigger_interconnect_tb_top;
  reg CLK_IN = 1'b0;
  reg RST_B_IN = 1'b0;
  reg [2:0] md = 3'h0;
  reg [31:0] r = 32'h00000000;
  reg [16:0] i1 = 17'h00000;
  reg [2:0] m1 = 3'h0;
  reg [2:0] m2 = 3'h0;
  reg [15:0] e;
  reg g;
  reg ok = 1'b0;
  wire [15:0] t;
  wire [15:0] o;
  wire [3:0] z;
  wire [11:0] q;
  reg [31:0] r1 = 32'h00000000;
  reg [31:0] sm = 32'h00000000;
  reg [31:0] sq = 32'h00000000;
  reg [1:0] pl = 2'h0;
  reg sn = 1'b0;
  reg ex;
  reg [15:0] e2;
  reg [3:0] ez;
  integer fail_count = 0;
  integer n_compared = 0;
  integer k;
  initial forever #20 CLK_IN = ~CLK_IN;
  trig_far_end FAR (.clk_in(CLK_IN), .trg_out(t));
  peripheral_trigger_interconnect DUT (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .POWER_MODE_IN(md),
    .GENERAL_TIMERS_TRG_IN(t[15:12]), .GENERAL_TIMERS_DMA_TRG_IN(t[11:8]),
    .CONVERTER_UNIT_WATCHDOG_IN(t[7]), .RTC_EVENT_IN(t[6]), .RTC_ALARM_TAMPER_IN(t[5]),
    .CLOCK_FAILURE_DETECTOR_IN(t[4]), .HARD_FAULT_IN(t[3]), .SRAM_PARITY_ERR_IN(t[2]),
    .FLASH_ECC_ERR_IN(t[1]), .VOLTAGE_LEVEL_DETECTOR_IN(t[0]), .CLK_SOURCES_IN(r[7:0]),
    .WIDE_TIMER_CLK_SEL_IN(r[10:8]), .TIMER_A_CLK_SEL_IN(r[13:11]),
    .TIMER_B_CLK_SEL_IN(r[16:14]), .GPIO_TRG_IN(r[17]), .RESET_SRC_INTERNAL_IN(r[18]),
    .IO_CONFIGURED_IN(r[19]), .VBAT_ONLY_IN(r[20]), .EXTI_IRQ_IN(r[21]), .RTC_WAKE_IN(r[22]),
    .WAKEUP_INPUTS_IN(r[24:23]), .SHUTDOWN_PULL_IN(r[26:25]), .UART_START_IN(r[27]),
    .UART_ADDR_MATCH_IN(r[28]), .UART_FRAME_IN(r[29]), .I2C_ADDR_MATCH_IN(r[30]),
    .RF_ACTIVITY_REQ_IN(r[31]), .SRAM_CLK_GATE_REQ_IN(r[1:0]),
    .GENERAL_TIMERS_TRG_OUT(o[15:12]), .DMA_MEM2MEM_TRG_OUT(o[11:8]),
    .ADVANCED_TIMER_TRG_OUT(o[7]), .TIMER_A_RTC_CH_OUT(o[6]),
    .FIRST_LOW_POWER_TIMER_TRG_OUT(o[5]), .SECOND_LOW_POWER_TIMER_TRG_OUT(o[4]),
    .WIDE_TIMER_CAPTURE_OUT(q[11]), .TIMER_A_CAPTURE_OUT(q[10]), .TIMER_B_CAPTURE_OUT(q[9]),
    .ADVANCED_TIMER_BREAK_OUT(o[3]), .TIMER_A_BREAK_OUT(o[2]), .TIMER_B_BREAK_OUT(o[1]),
    .GENERAL_TIMERS_EXT_TRG_OUT(q[8]), .CONVERTER_UNIT_EXT_TRG_OUT(q[7]),
    .FIRST_LP_TIMER_EXT_TRG_OUT(q[6]), .SECOND_LP_TIMER_EXT_TRG_OUT(q[5]), .IO_ANALOG_OUT(z[3]),
    .IO_SCHMITT_EN_OUT(z[2]), .RESET_PULLUP_EN_OUT(o[0]), .LOW_POWER_EXIT_OUT(q[4]),
    .IO_PULL_OUT(q[1:0]), .STOP_WAKE_IRQ_OUT(q[3]), .FAST_EXTERNAL_OSCILLATOR_EN_OUT(q[2]),
    .SRAM_CLK_EN_OUT(z[1:0]));
  task chk(input [8*6:1] nm, input [15:0] s, input [15:0] x);
    n_compared = n_compared + 1;
    if (s !== x) begin
      fail_count = fail_count + 1;
      $display("ERROR %0s exp %h seen %h", nm, x, s);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reference: input one edge back, gated by the mode two edges back
  always @(negedge CLK_IN) begin
    g = m2 < 3'h4;
    e = {i1[15:6] & {10{g}}, i1[5] & (m2 < 3'h6), i1[5] & (m2 < 3'h5), {3{|i1[4:0] & g}}, !i1[16]};
    // pull state: captured in shutdown, cleared one edge after leaving
    if (!(ok && RST_B_IN)) begin
      pl = 2'h0;
      sn = 1'b0;
    end else begin
      if (m2 == 3'h7) pl = r1[26:25];
      else if (sn) pl = 2'h0;
      sn = m2 == 3'h7;
    end
    ex = r1[20] ? 1'b0 : (m2 > 3'h5) ? ((|sq[24:23]) | r1[22]) : ((m2[2:1] == 2'h2) &
      (r1[21] | r1[22]));
    e2 = {4'h0, sq[r1[10:8]] & g, sq[r1[13:11]] & g, sq[r1[16:14]] & g, {2{sq[17] & g}},
      sq[17] & (m2 < 3'h6), sq[17] & (m2 < 3'h5), ex, (m2 == 3'h4) & (|r1[30:27]), r1[31], pl};
    ez = {~r1[19], r1[19], (m2 == 3'h1 || m2 == 3'h3) ? ~r1[1:0] : 2'h3};
    if (ok && RST_B_IN) begin
      chk("routes", o, e);
      chk("others", {4'h0, q}, e2);
      chk("io", {12'h000, z}, {12'h000, ez});
    end
    // pin bits pass two sync stages; both clear on reset
    if (!(ok && RST_B_IN)) begin
      sq = 32'h00000000;
      sm = 32'h00000000;
    end else begin
      sq = sm;
      sm = r1;
    end
    r1 = r;
    m2 = ok ? m1 : 3'h0;
    m1 = md;
    i1 = {r[18], t};
    ok = RST_B_IN;
  end
  initial begin
    k = $urandom(70);
    repeat (6) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    for (k = 0; k < 4000; k = k + 1) begin
      @(posedge CLK_IN);
      r <= $urandom;
      // first sweep holds each of the eight modes for 20 cycles
      if (k < 160) md <= 3'(k / 20);
      else if ($urandom % 6 == 0) md <= 3'($urandom);
      if (k == 2000) RST_B_IN <= 1'b0;
      if (k == 2004) begin
        chk("io", {12'h000, z}, 16'h000B);
        chk("rstout", o, 16'h0001);
        RST_B_IN <= 1'b1;
      end
    end
    conclude;
  end
endmodule // peripheral_trigger_interconnect_tb_top
